// ### logic/osdcs_pkg.sv
// osdcs_pkg: register map, field positions, reset values and timing counts
// for the eight-channel overlay register bank.
// assumes: 20 MHz system clock; host port delivers 8-bit address/data strobes.
package osdcs_pkg;

  // ----------------------------------------------------------------------
  // block and register addressing
  // ----------------------------------------------------------------------
  localparam int          NUM_CHANNELS      = 8;
  localparam logic [3:0]  BLOCK_MULTI       = 4'h8;
  localparam logic [3:0]  REG_PIXEL_HIGH    = 4'h0;
  localparam logic [3:0]  REG_PIXEL_LOW     = 4'h1;
  localparam logic [3:0]  REG_COLUMN        = 4'h2;
  localparam logic [3:0]  REG_ROW_HIGH      = 4'h3;
  localparam logic [3:0]  REG_ROW_LOW       = 4'h4;
  localparam logic [3:0]  REG_STATUS        = 4'h5;
  localparam logic [3:0]  REG_COMMAND       = 4'h6;
  localparam logic [3:0]  REG_HSHIFT        = 4'h7;
  localparam logic [3:0]  REG_VSHIFT        = 4'h8;
  localparam logic [3:0]  REG_SHARE_SRC     = 4'h9;
  localparam logic [3:0]  REG_BEGIN_HIGH    = 4'hA;
  localparam logic [3:0]  REG_BEGIN_LOW     = 4'hB;
  localparam logic [3:0]  REG_END_HIGH      = 4'hC;
  localparam logic [3:0]  REG_END_LOW       = 4'hD;
  localparam logic [3:0]  REG_SYNC_LOSS_ALL = 4'h5;
  localparam logic [3:0]  REG_MULTI_WRITE   = 4'h6;
  localparam logic [3:0]  REG_MULTI_CONTROL = 4'h7;

  // ----------------------------------------------------------------------
  // field positions and values
  // ----------------------------------------------------------------------
  localparam int          CMD_READ_BIT      = 0;
  localparam int          CMD_WRITE_BIT     = 1;
  localparam int          ST_LOSS_BIT       = 0;
  localparam int          ST_SUPPRESS_BIT   = 1;
  localparam int          ST_IMMEDIATE_BIT  = 2;
  localparam int          ST_COLINC_BIT     = 3;
  localparam int          ST_LINEINC_BIT    = 4;
  localparam logic [7:0]  SHIFT_RESET       = 8'h80;
  localparam logic [7:0]  COLUMN_MAX        = 8'hB1;
  localparam logic [8:0]  ROW_MAX           = 9'h1FF;
  localparam logic [8:0]  NTSC_LINE_MAX     = 9'h1E3;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int          CLOCK_HZ          = 20_000_000;
  localparam int          LINE_PERIOD_NS    = 64_000;
  localparam int          LINE_CYCLES       = LINE_PERIOD_NS / (1_000_000_000 / CLOCK_HZ);
  localparam int          CNT_W             = 12;

  typedef enum logic [1:0] {
    OSDCS_IDLE,
    OSDCS_WRITE,
    OSDCS_READ
  } osdcs_state_type;

endpackage : osdcs_pkg

// ### logic/osdcs_regs.sv
// osdcs_regs: per-channel and multichannel host registers of the overlay generator.
// assumes: host port presents a one-cycle write or read strobe with an 8-bit
// address; memory port is a request/done handshake to the SDRAM controller.
//
// Operation
// - command 0x02 stores pixel word to memory
// - command 0x01 fetches pixel word into registers
// - command 0x03 stores then reads back
// - horizontal shift resets to 128 quad pixels
// - overlay outside active video is suppressed
// - vertical shift resets to 128 lines
// - vertical shift may apply within two frames
// - share band lines come from source channel
// - sharing only between channels of same parity
// - lowest selected channel of parity wins
// - share lines update immediately or at field
// - share begin is 9 bits, high bit 0
// - begin value commits on low half write
// - end value commits on low half write
// - multi column increments, saturates at 177
// - multi line increments, saturates at 511
// - four nibble pixels, leftmost in high nibble
// - sync loss bit per channel after line
// - multi write trigger clears after cycle
// - multi control holds only increment bits
// - even line address field one, odd two
// - status bits: lineinc colinc immediate suppress loss
// - upper nibble block, lower nibble register
`timescale 1ns/1ps
module osdcs_regs
  import osdcs_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_rd_i,
  input  wire logic [7:0]  host_addr_i,
  input  wire logic [7:0]  host_wdata_i,
  output logic [7:0]       host_rdata_o,
  input  wire logic [7:0]  video_sense_input_i,
  input  wire logic [7:0]  field_start_i,
  input  wire logic [7:0]  active_video_i,
  input  wire logic [7:0]  frame_start_i,
  output logic             mem_req_o,
  output logic             mem_write_o,
  output logic [2:0]       mem_channel_o,
  output logic [7:0]       mem_column_o,
  output logic [8:0]       mem_row_o,
  output logic             mem_field_o,
  output logic [15:0]      mem_wdata_o,
  input  wire logic        mem_done_i,
  input  wire logic [15:0] mem_rdata_i,
  output logic [7:0]       overlay_enable_o,
  output logic [63:0]      hshift_o,
  output logic [63:0]      vshift_o,
  output logic [23:0]      share_from_o,
  output logic [7:0]       share_on_o,
  output logic [71:0]      share_begin_line_o,
  output logic [71:0]      share_end_line_o,
  output logic [7:0]       sync_loss_all_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0][7:0]  pix_hi;
    logic [7:0][7:0]  pix_lo;
    logic [7:0][7:0]  column;
    logic [7:0][8:0]  row;
    logic [7:0][3:0]  ctrl;      // lineinc colinc immediate suppress
    logic [7:0][7:0]  hshift;
    logic [7:0][7:0]  vshift;
    logic [7:0][7:0]  vshift_live;
    logic [7:0][1:0]  vframes;
    logic [7:0][7:0]  share_src;
    logic [7:0]       m_hi;
    logic [7:0]       m_lo;
    logic [7:0]       m_col;
    logic [8:0]       m_row;
    logic [1:0]       m_ctrl;    // lineinc colinc
    logic [7:0]       m_trig;
    osdcs_state_type  fsm;
    logic             readback;
    logic             multi;
    logic [2:0]       chan;
    logic [7:0]       rdata;
    logic             req;
    logic [7:0]       ov_en;
    logic [23:0]      share_from;
    logic [7:0]       share_on;
  } osdcs_regs_type;

  osdcs_regs_type state_ff;
  osdcs_regs_type nxt_state;

  logic [7:0]       loss;
  logic [7:0][8:0]  beg_line;
  logic [7:0][8:0]  end_line;
  logic [7:0]       beg_hi;
  logic [7:0]       end_hi;
  logic [7:0][7:0]  beg_lo;
  logic [7:0][7:0]  end_lo;
  logic [7:0]       wr_bh;
  logic [7:0]       wr_bl;
  logic [7:0]       wr_eh;
  logic [7:0]       wr_el;

  wire logic [3:0] blk = host_addr_i[7:4];
  wire logic [3:0] idx = host_addr_i[3:0];

  // ----------------------------------------------------------------------
  // per-channel helpers
  // ----------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    assign wr_bh[c] = host_wr_i && blk == 4'(c) && idx == REG_BEGIN_HIGH;
    assign wr_bl[c] = host_wr_i && blk == 4'(c) && idx == REG_BEGIN_LOW;
    assign wr_eh[c] = host_wr_i && blk == 4'(c) && idx == REG_END_HIGH;
    assign wr_el[c] = host_wr_i && blk == 4'(c) && idx == REG_END_LOW;

    osdcs_sync_watch u_watch (
      .clock_i  (clock_i),
      .resetn_i (resetn_i),
      .sync_i   (video_sense_input_i[c]),
      .limit_i  (CNT_W'(LINE_CYCLES)),
      .loss_o   (loss[c])
    );

    osdcs_share_line u_begin (
      .clock_i     (clock_i),
      .resetn_i    (resetn_i),
      .wr_high_i   (wr_bh[c]),
      .wr_low_i    (wr_bl[c]),
      .data_i      (host_wdata_i),
      .immediate_i (state_ff.ctrl[c][1]),
      .field_i     (field_start_i[c]),
      .high_o      (beg_hi[c]),
      .low_o       (beg_lo[c]),
      .line_o      (beg_line[c])
    );

    osdcs_share_line u_end (
      .clock_i     (clock_i),
      .resetn_i    (resetn_i),
      .wr_high_i   (wr_eh[c]),
      .wr_low_i    (wr_el[c]),
      .data_i      (host_wdata_i),
      .immediate_i (state_ff.ctrl[c][1]),
      .field_i     (field_start_i[c]),
      .high_o      (end_hi[c]),
      .low_o       (end_lo[c]),
      .line_o      (end_line[c])
    );
  end

  // lowest selected channel of matching parity
  function automatic logic [3:0] osdcs_pick(input logic [7:0] src, input int c);
    logic [3:0] pick;
    pick = 4'h0;
    for (int k = 7; k >= 0; k--) begin
      if (src[k] && (k % 2) == (c % 2)) begin
        pick = {1'b1, 3'(k)};
      end
    end
    return pick;
  endfunction : osdcs_pick

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [3:0] p;
    logic [2:0] ch;
    p         = 4'h0;
    ch        = blk[2:0];
    nxt_state = state_ff;
    nxt_state.req = 1'b0;

    // host writes; a write that collides with a fetch result loses to it
    if (host_wr_i && !blk[3]) begin
      unique case (idx)
        REG_PIXEL_HIGH: nxt_state.pix_hi[ch] = host_wdata_i;
        REG_PIXEL_LOW:  nxt_state.pix_lo[ch] = host_wdata_i;
        REG_COLUMN:     nxt_state.column[ch] = host_wdata_i;
        REG_ROW_HIGH:   nxt_state.row[ch][8] = host_wdata_i[0];
        REG_ROW_LOW:    nxt_state.row[ch][7:0] = host_wdata_i;
        REG_STATUS:     nxt_state.ctrl[ch] = host_wdata_i[4:1];
        REG_HSHIFT:     nxt_state.hshift[ch] = host_wdata_i;
        REG_VSHIFT:     nxt_state.vshift[ch] = host_wdata_i;
        REG_SHARE_SRC:  nxt_state.share_src[ch] = host_wdata_i;
        default: ;
      endcase
    end else if (host_wr_i && blk == BLOCK_MULTI) begin
      unique case (idx)
        REG_PIXEL_HIGH:    nxt_state.m_hi = host_wdata_i;
        REG_PIXEL_LOW:     nxt_state.m_lo = host_wdata_i;
        REG_COLUMN:        nxt_state.m_col = host_wdata_i;
        REG_ROW_HIGH:      nxt_state.m_row[8] = host_wdata_i[0];
        REG_ROW_LOW:       nxt_state.m_row[7:0] = host_wdata_i;
        REG_MULTI_CONTROL: nxt_state.m_ctrl = host_wdata_i[4:3];
        default: ;
      endcase
    end

    // transfer sequencer
    unique case (state_ff.fsm)
      OSDCS_IDLE: begin
        if (host_wr_i && !blk[3] && idx == REG_COMMAND
            && host_wdata_i[CMD_WRITE_BIT:CMD_READ_BIT] != 2'b00) begin
          nxt_state.multi    = 1'b0;
          nxt_state.chan     = ch;
          nxt_state.readback = host_wdata_i[CMD_READ_BIT];
          nxt_state.req      = 1'b1;
          nxt_state.fsm      = host_wdata_i[CMD_WRITE_BIT] ? OSDCS_WRITE
                                                           : OSDCS_READ;
        end else if (host_wr_i && blk == BLOCK_MULTI && idx == REG_MULTI_WRITE
                     && host_wdata_i != 8'h00) begin
          nxt_state.m_trig   = host_wdata_i;
          nxt_state.multi    = 1'b1;
          nxt_state.readback = 1'b0;
          nxt_state.req      = 1'b1;
          nxt_state.fsm      = OSDCS_WRITE;
          for (int k = 7; k >= 0; k--) begin
            if (host_wdata_i[k]) nxt_state.chan = 3'(k);
          end
        end
      end
      OSDCS_WRITE: begin
        if (mem_done_i) begin
          if (state_ff.multi) begin
            nxt_state.m_trig[state_ff.chan] = 1'b0;
            if ((state_ff.m_trig & ~(8'h01 << state_ff.chan)) != 8'h00) begin
              nxt_state.req = 1'b1;
              for (int k = 7; k >= 0; k--) begin
                if (state_ff.m_trig[k] && 3'(k) != state_ff.chan) nxt_state.chan = 3'(k);
              end
            end else begin
              nxt_state.fsm = OSDCS_IDLE;
              if (state_ff.m_ctrl[0] && state_ff.m_col < COLUMN_MAX) begin
                nxt_state.m_col = state_ff.m_col + 8'h01;
              end
              if (state_ff.m_ctrl[1] && state_ff.m_row < ROW_MAX) begin
                nxt_state.m_row = state_ff.m_row + 9'h001;
              end
            end
          end else if (state_ff.readback) begin
            nxt_state.req = 1'b1;
            nxt_state.fsm = OSDCS_READ;
          end else begin
            nxt_state.fsm = OSDCS_IDLE;
          end
        end
      end
      OSDCS_READ: begin
        if (mem_done_i) begin
          nxt_state.fsm = OSDCS_IDLE;
          nxt_state.pix_hi[state_ff.chan] = mem_rdata_i[15:8];
          nxt_state.pix_lo[state_ff.chan] = mem_rdata_i[7:0];
        end
      end
    endcase

    // per-channel autoincrement after own transfer
    if (mem_done_i && !state_ff.multi && state_ff.fsm != OSDCS_IDLE
        && !(state_ff.fsm == OSDCS_WRITE && state_ff.readback)) begin
      if (state_ff.ctrl[state_ff.chan][2] && state_ff.column[state_ff.chan] < COLUMN_MAX) begin
        nxt_state.column[state_ff.chan] = state_ff.column[state_ff.chan] + 8'h01;
      end
      if (state_ff.ctrl[state_ff.chan][3] && state_ff.row[state_ff.chan] < ROW_MAX) begin
        nxt_state.row[state_ff.chan] = state_ff.row[state_ff.chan] + 9'h001;
      end
    end

    // vertical shift applied at the second frame start after it changes
    for (int c = 0; c < NUM_CHANNELS; c++) begin
      if (state_ff.vshift_live[c] == state_ff.vshift[c]) begin
        nxt_state.vframes[c] = 2'd0;
      end else if (frame_start_i[c]) begin
        if (state_ff.vframes[c] == 2'd1) begin
          nxt_state.vshift_live[c] = state_ff.vshift[c];
          nxt_state.vframes[c]     = 2'd0;
        end else begin
          nxt_state.vframes[c] = state_ff.vframes[c] + 2'd1;
        end
      end
      // suppress bit and region outside active video gate the key
      nxt_state.ov_en[c] = active_video_i[c] && !state_ff.ctrl[c][0];
      p = osdcs_pick(state_ff.share_src[c], c);
      nxt_state.share_on[c]        = p[3] && state_ff.share_src[c] != 8'h00;
      nxt_state.share_from[c*3 +: 3] = p[2:0];
    end

    // read path: one cycle behind the strobe
    nxt_state.rdata = 8'h00;
    if (host_rd_i && !blk[3]) begin
      unique case (idx)
        REG_PIXEL_HIGH: nxt_state.rdata = state_ff.pix_hi[ch];
        REG_PIXEL_LOW:  nxt_state.rdata = state_ff.pix_lo[ch];
        REG_COLUMN:     nxt_state.rdata = state_ff.column[ch];
        REG_ROW_HIGH:   nxt_state.rdata = {7'h00, state_ff.row[ch][8]};
        REG_ROW_LOW:    nxt_state.rdata = state_ff.row[ch][7:0];
        REG_STATUS:     nxt_state.rdata = {3'h0, state_ff.ctrl[ch], loss[ch]};
        REG_COMMAND:    nxt_state.rdata = 8'h00;
        REG_HSHIFT:     nxt_state.rdata = state_ff.hshift[ch];
        REG_VSHIFT:     nxt_state.rdata = state_ff.vshift[ch];
        REG_SHARE_SRC:  nxt_state.rdata = state_ff.share_src[ch];
        REG_BEGIN_HIGH: nxt_state.rdata = {7'h00, beg_hi[ch]};
        REG_BEGIN_LOW:  nxt_state.rdata = beg_lo[ch];
        REG_END_HIGH:   nxt_state.rdata = {7'h00, end_hi[ch]};
        REG_END_LOW:    nxt_state.rdata = end_lo[ch];
        default:        nxt_state.rdata = 8'h00;
      endcase
    end else if (host_rd_i && blk == BLOCK_MULTI) begin
      unique case (idx)
        REG_PIXEL_HIGH:    nxt_state.rdata = state_ff.m_hi;
        REG_PIXEL_LOW:     nxt_state.rdata = state_ff.m_lo;
        REG_COLUMN:        nxt_state.rdata = state_ff.m_col;
        REG_ROW_HIGH:      nxt_state.rdata = {7'h00, state_ff.m_row[8]};
        REG_ROW_LOW:       nxt_state.rdata = state_ff.m_row[7:0];
        REG_SYNC_LOSS_ALL: nxt_state.rdata = loss;
        REG_MULTI_WRITE:   nxt_state.rdata = state_ff.m_trig;
        REG_MULTI_CONTROL: nxt_state.rdata = {3'h0, state_ff.m_ctrl, 3'h0};
        default:           nxt_state.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_ff             <= '0;
      state_ff.hshift      <= {NUM_CHANNELS{SHIFT_RESET}};
      state_ff.vshift      <= {NUM_CHANNELS{SHIFT_RESET}};
      state_ff.vshift_live <= {NUM_CHANNELS{SHIFT_RESET}};
      state_ff.fsm         <= OSDCS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      mem_req_o          <= 1'b0;
      mem_write_o        <= 1'b0;
      mem_channel_o      <= 3'h0;
      mem_column_o       <= 8'h00;
      mem_row_o          <= 9'h000;
      mem_field_o        <= 1'b0;
      mem_wdata_o        <= 16'h0000;
      share_begin_line_o <= '0;
      share_end_line_o   <= '0;
    end else begin
      mem_req_o     <= nxt_state.req;
      mem_write_o   <= nxt_state.fsm == OSDCS_WRITE;
      mem_channel_o <= nxt_state.chan;
      mem_column_o  <= nxt_state.multi ? nxt_state.m_col : nxt_state.column[nxt_state.chan];
      mem_row_o     <= nxt_state.multi ? nxt_state.m_row : nxt_state.row[nxt_state.chan];
      mem_field_o   <= nxt_state.multi ? nxt_state.m_row[0]
                                       : nxt_state.row[nxt_state.chan][0];
      mem_wdata_o   <= nxt_state.multi ? {nxt_state.m_hi, nxt_state.m_lo}
                                       : {nxt_state.pix_hi[nxt_state.chan],
                                          nxt_state.pix_lo[nxt_state.chan]};
      share_begin_line_o <= beg_line;
      share_end_line_o   <= end_line;
    end
  end

  assign host_rdata_o     = state_ff.rdata;
  assign overlay_enable_o = state_ff.ov_en;
  assign hshift_o         = state_ff.hshift;
  assign vshift_o         = state_ff.vshift_live;
  assign share_from_o     = state_ff.share_from;
  assign share_on_o       = state_ff.share_on;
  assign sync_loss_all_o  = loss;

endmodule : osdcs_regs

// ### logic/osdcs_share_line.sv
// osdcs_share_line: one 9-bit share line value with staged high half,
// low-half commit and field-boundary update.
// assumes: wr strobes are one-cycle pulses from the host decode.
`timescale 1ns/1ps
module osdcs_share_line
  import osdcs_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       wr_high_i,
  input  wire logic       wr_low_i,
  input  wire logic [7:0] data_i,
  input  wire logic       immediate_i,
  input  wire logic       field_i,
  output logic            high_o,
  output logic [7:0]      low_o,
  output logic [8:0]      line_o
);

  typedef struct packed {
    logic       high;
    logic [7:0] low;
    logic [8:0] pend;
    logic       pend_valid;
    logic [8:0] line;
  } osdcs_line_type;

  osdcs_line_type state_ff;
  osdcs_line_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (wr_high_i) begin
      nxt_state.high = data_i[0];
    end
    if (wr_low_i) begin
      nxt_state.low        = data_i;
      nxt_state.pend       = {state_ff.high, data_i};
      nxt_state.pend_valid = 1'b1;
    end
    if (state_ff.pend_valid && (immediate_i || field_i)) begin
      nxt_state.line = state_ff.pend;
      if (!wr_low_i) begin
        nxt_state.pend_valid = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign high_o = state_ff.high;
  assign low_o  = state_ff.low;
  assign line_o = state_ff.line;

endmodule : osdcs_share_line

// ### logic/osdcs_sync_watch.sv
// osdcs_sync_watch: per-channel loss-of-sync detector.
// assumes: sync_i is an asynchronous pin level; a sync pulse is a low level.
`timescale 1ns/1ps
module osdcs_sync_watch
  import osdcs_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic resetn_i,
  input  wire logic sync_i,
  input  wire logic [CNT_W-1:0] limit_i,
  output logic      loss_o
);

  typedef struct packed {
    logic             meta;
    logic             sync;
    logic             prev;
    logic [CNT_W-1:0] count;
    logic             loss;
  } osdcs_watch_type;

  osdcs_watch_type state_ff;
  osdcs_watch_type nxt_state;

  always_comb begin
    nxt_state      = state_ff;
    nxt_state.meta = sync_i;
    nxt_state.sync = state_ff.meta;
    nxt_state.prev = state_ff.sync;
    // a falling edge of sync counts as a valid pulse and clears the flag
    if (state_ff.prev && !state_ff.sync) begin
      nxt_state.count = '0;
      nxt_state.loss  = 1'b0;
    end else if (state_ff.count >= limit_i) begin
      nxt_state.loss = 1'b1;
    end else begin
      nxt_state.count = state_ff.count + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign loss_o = state_ff.loss;

endmodule : osdcs_sync_watch

// ### tb/osdcs_mem_model.sv
// memory side model: answers after 1 or 9 cycles, one request at a time
`timescale 1ns/1ps
module osdcs_mem_model (
  input wire logic clock_i, slow_i, req_i, write_i,
  input wire logic [19:0] key_i,
  input wire logic [15:0] wdata_i,
  output logic done_o = 1'b0,
  output logic [15:0] rdata_o = 16'h0000
);
  logic [15:0] m [int];
  int n = 0;
  always @(posedge clock_i) if (req_i) begin
    repeat (slow_i ? 9 : 1) @(posedge clock_i);
    if (write_i) m[key_i] = wdata_i;
    else rdata_o <= m[key_i];
    done_o <= 1'b1;
    n++;
    @(posedge clock_i);
    done_o <= 1'b0;
    rdata_o <= ~rdata_o; // stale data must not pass for valid
  end
endmodule : osdcs_mem_model

// ### tb/osdcs_properties.sv
// port checks of the overlay register bank
// bound to osdcs_regs; the memory side answers each request once
`timescale 1ns/1ps
module osdcs_props (
  input wire logic clock_i, resetn_i, host_wr_i, host_rd_i, mem_req_o, mem_write_o, mem_done_i,
  input wire logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, active_video_i,
  input wire logic [7:0] overlay_enable_o,
  input wire logic [15:0] mem_wdata_o,
  input wire logic [63:0] hshift_o
);
  logic busy_ff;
  logic cmd;
  always_ff @(posedge clock_i) busy_ff <= resetn_i && (mem_req_o || busy_ff && !mem_done_i);
  assign cmd = host_wr_i && host_addr_i[7:4] < 4'h8 && host_addr_i[3:0] == 4'h6 && !busy_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  property p_pulse; mem_req_o |=> !mem_req_o; endproperty
  a_pulse: assert property (p_pulse) else $error("long request");
  property p_store; cmd && !mem_req_o && host_wdata_i[1] |=> mem_req_o && mem_write_o; endproperty
  a_store: assert property (p_store) else $error("no store");
  property p_fetch; cmd && !mem_req_o && host_wdata_i == 8'h01 |=> mem_req_o && !mem_write_o; endproperty
  a_fetch: assert property (p_fetch) else $error("no fetch");
  property p_hold; busy_ff && !mem_done_i |=> $stable(mem_wdata_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_turn; mem_done_i && busy_ff |=> !mem_write_o || mem_req_o; endproperty
  a_turn: assert property (p_turn) else $error("write stuck");
  property p_hole; host_rd_i && (host_addr_i > 8'h8D || host_addr_i[3:0] > 4'hD)
    |=> host_rdata_o == 8'h00; endproperty
  a_hole: assert property (p_hole) else $error("reserved read");
  property p_reset; $rose(resetn_i) |-> hshift_o == {8{8'h80}}; endproperty
  a_reset: assert property (p_reset) else $error("shift reset");
  property p_blank; overlay_enable_o[0] |-> $past(active_video_i[0]); endproperty
  a_blank: assert property (p_blank) else $error("overlay outside video");
endmodule : osdcs_props
bind osdcs_regs osdcs_props u_props (.clock_i, .resetn_i, .host_wr_i, .host_rd_i, .mem_req_o,
  .mem_write_o, .mem_done_i, .host_addr_i, .host_wdata_i, .host_rdata_o, .active_video_i,
  .overlay_enable_o, .mem_wdata_o, .hshift_o);

// ### tb/osdcs_regs_tb.sv
// self-checking bench of the overlay register bank
// memory side is osdcs_mem_model; inputs change on the falling edge
`timescale 1ns/1ps
module osdcs_regs_tb;
  logic clock_i = 0, resetn_i = 0, host_wr_i = 0, host_rd_i = 0, slow_i = 0;
  logic [7:0] host_addr_i = 0, host_wdata_i = 0, host_rdata_o, overlay_enable_o, share_on_o;
  logic [7:0] video_sense_input_i = 8'hFF, field_start_i = 0, active_video_i = 8'hFF;
  logic [7:0] frame_start_i = 0, sync_loss_all_o, mem_column_o;
  logic mem_req_o, mem_write_o, mem_done_i, mem_field_o;
  logic [2:0] mem_channel_o;
  logic [8:0] mem_row_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  logic [63:0] hshift_o, vshift_o;
  logic [23:0] share_from_o;
  logic [71:0] share_begin_line_o, share_end_line_o;
  int compares = 0, miscompares = 0;
  always #25 clock_i = ~clock_i;
  osdcs_regs DUT (.clock_i, .resetn_i, .host_wr_i, .host_rd_i, .host_addr_i, .host_wdata_i,
    .host_rdata_o, .video_sense_input_i, .field_start_i, .active_video_i, .frame_start_i,
    .mem_req_o, .mem_write_o, .mem_channel_o, .mem_column_o, .mem_row_o, .mem_field_o,
    .mem_wdata_o, .mem_done_i, .mem_rdata_i, .overlay_enable_o, .hshift_o, .vshift_o,
    .share_from_o, .share_on_o, .share_begin_line_o, .share_end_line_o, .sync_loss_all_o);
  osdcs_mem_model u_mem (.clock_i, .slow_i, .req_i(mem_req_o), .write_i(mem_write_o),
    .key_i({mem_channel_o, mem_row_o, mem_column_o}), .wdata_i(mem_wdata_o),
    .done_o(mem_done_i), .rdata_o(mem_rdata_i));
  task automatic chk(input logic [71:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, d);
    @(negedge clock_i);
    {host_addr_i, host_wdata_i, host_wr_i} = {a, d, 1'b1};
    @(negedge clock_i);
    host_wr_i = 0;
    repeat (2) @(negedge clock_i);
  endtask : w
  task automatic r(input logic [7:0] a, e);
    @(negedge clock_i);
    {host_addr_i, host_rd_i} = {a, 1'b1};
    @(negedge clock_i);
    host_rd_i = 0;
    chk(host_rdata_o, e);
  endtask : r
  task automatic wt(input int n);
    repeat (300) if (u_mem.n < n) @(negedge clock_i);
    repeat (3) @(negedge clock_i);
    chk(u_mem.n, n);
  endtask : wt
  task automatic pl(ref logic [7:0] s, input logic [7:0] v);
    @(negedge clock_i);
    s = v;
    @(negedge clock_i);
    s = 0;
    repeat (2) @(negedge clock_i);
  endtask : pl
  task automatic t_pix;
    w(8'h22, 8'h05); w(8'h23, 8'h01); w(8'h24, 8'h02); w(8'h20, 8'h12); w(8'h21, 8'h34);
    w(8'h26, 8'h02);
    wt(1);
    chk(u_mem.m[{3'd2, 9'h102, 8'h05}], 16'h1234);
    w(8'h20, 8'h00); slow_i = 1; w(8'h26, 8'h01); wt(2); r(8'h20, 8'h12);
    w(8'h25, 8'h08); w(8'h21, 8'h78); w(8'h26, 8'h03); wt(4); r(8'h21, 8'h78);
    chk(u_mem.m[{3'd2, 9'h102, 8'h05}], 16'h1278);
    r(8'h22, 8'h06);
    $display("pixel test end");
  endtask : t_pix
  task automatic t_multi;
    w(8'h87, 8'hFF); r(8'h87, 8'h18);
    w(8'h82, 8'hB0); w(8'h83, 8'h01); w(8'h84, 8'hFE); w(8'h80, 8'hAB); w(8'h81, 8'hCD);
    w(8'h86, 8'h05); wt(6); r(8'h86, 8'h00);
    chk(u_mem.m[{3'd2, 9'h1FE, 8'hB0}], 16'hABCD);
    w(8'h86, 8'h01); wt(7); r(8'h82, 8'hB1); r(8'h84, 8'hFF);
    chk(mem_field_o, 1);
    $display("multi test end");
  endtask : t_multi
  task automatic t_share;
    w(8'h15, 8'h04); w(8'h1A, 8'h01); w(8'h1B, 8'h23); w(8'h1A, 8'h00);
    chk(share_begin_line_o[17:9], 9'h123);
    w(8'h1C, 8'h01); w(8'h1D, 8'hE3); chk(share_end_line_o[17:9], 9'h1E3);
    w(8'h19, 8'h28); chk({share_on_o[1], share_from_o[5:3]}, 4'hB);
    w(8'h19, 8'h04); chk(share_on_o[1], 1'b0);
    w(8'h2B, 8'h10); chk(share_begin_line_o[26:18], 9'h000);
    pl(field_start_i, 8'h04); chk(share_begin_line_o[26:18], 9'h010);
    active_video_i = 8'hFE; pl(field_start_i, 0); chk(overlay_enable_o, 8'hFE);
    w(8'h05, 8'h02); chk(overlay_enable_o[1:0], 2'b10);
    $display("share test end");
  endtask : t_share
  task automatic t_sync;
    w(8'h08, 8'h90); pl(frame_start_i, 8'h01); chk(vshift_o[7:0], 8'h80);
    pl(frame_start_i, 8'h01); chk(vshift_o[7:0], 8'h90);
    repeat (1300) @(negedge clock_i);
    r(8'h85, 8'hFF); chk(sync_loss_all_o, 8'hFF); r(8'h05, 8'h03);
    video_sense_input_i = 8'h00;
    repeat (4) @(negedge clock_i);
    video_sense_input_i = 8'hFF;
    repeat (4) @(negedge clock_i);
    r(8'h85, 8'h00);
    $display("sync test end");
  endtask : t_sync
  task automatic print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(negedge clock_i);
    resetn_i = 1;
    r(8'h37, 8'h80); r(8'h08, 8'h80); r(8'h9E, 8'h00); r(8'h0F, 8'h00);
    t_pix();
    t_multi();
    t_share();
    t_sync();
    print_verdict();
  end
  initial begin
    #(50 * 4000);
    miscompares++;
    print_verdict();
  end
endmodule : osdcs_regs_tb
